// ==== logic/pmx_pkg.sv ====
// package for the port six to eight pin multiplexer
package pmx_pkg;
	// register indices; some printed offsets are odd, byte address = 4*index
	localparam logic [15:0] IDX_P7_DATA = 16'h0091;
	localparam logic [15:0] IDX_P8_DATA = 16'h0092;
	localparam logic [15:0] IDX_P7_PU = 16'h009E;
	localparam logic [15:0] IDX_P8_PU = 16'h009F;
	localparam logic [15:0] IDX_P7_DIR = 16'h00E1;
	localparam logic [15:0] IDX_P8_DIR = 16'h00E9;
	localparam logic [15:0] IDX_P7_OD = 16'h1007;
	localparam logic [15:0] IDX_P8_OD = 16'h1008;
	localparam logic [15:0] IDX_P8_FSR = 16'h100B;
	localparam logic [15:0] IDX_P6_FSRL = 16'h1014;
	localparam logic [15:0] IDX_P6_FSRH = 16'h1015;
	localparam logic [15:0] IDX_P7_FSRL = 16'h1016;
	localparam logic [15:0] IDX_P7_FSRH = 16'h1017;
	localparam logic [15:0] IDX_P6_PIN = 16'h1018;
	localparam int ADDR_W = 18;
	localparam logic [7:0] RST_VAL = 8'h00;
	localparam logic [7:0] P6H_MASK = 8'h03;
	localparam logic [7:0] P7H_MASK = 8'h0F;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// two-bit function codes
	localparam logic [1:0] FN_PORT = 2'h0;
	localparam logic [1:0] FN_ALT1 = 2'h1;
	localparam logic [1:0] FN_ALT2 = 2'h2;

	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
		logic [7:0] pu;
	} pmx_pins_t;

	// lines from peripherals driving pins
	typedef struct packed {
		logic timer_seven_output;
		logic timer_eight_output;
		logic pwm_out_a_a;
		logic pwm_out_a_b;
		logic pwm_out_b_a;
		logic pwm_out_b_b;
		logic pwm_out_c_a;
		logic pwm_out_c_b;
		logic serial2_transmit_out;
		logic [3:0] lcd_common;
		logic [3:0] lcd_bias;
		logic [7:0] lcd_segment;
	} pmx_periph_t;

	// sampled pin inputs, analog and select strobes towards peripherals
	typedef struct packed {
		logic ext_irq_line_17;
		logic ext_irq_line_18;
		logic event_counter_input_7;
		logic serial2_receive_in;
		logic analog_channel_eight;
		logic analog_channel_nine;
		logic analog_channel_ten;
		logic low_voltage_ref_input;
		logic lcd_cap_low_pin;
		logic lcd_cap_high_pin;
	} pmx_fnin_t;
endpackage

// ==== logic/pmx_top.sv ====
// register file and pin multiplexer for ports six, seven and eight
`timescale 1ns/1ps
// Function
// (R01) ports seven and eight each have an 8-bit read/write data register
// (R02) direction bit 0 makes the pin an input, 1 an output
// (R03) pull-up select bit 0 disables, 1 enables the pull-up
// (R04) open-drain bit 0 push-pull, 1 open-drain output
// (R05) p6 low bits 7:6 pick pin 3: port/ec7, analog nine, lvi ref
// (R06) p6 low bits 5:4 pick pin 2: port/irq17, analog eight, timer seven
// (R07) p6 low bits 3:2 pick pin 1: port/irq18, cap low, timer eight/pwm a-a
// (R08) p6 low bits 1:0 pick pin 0: port, cap high, pwm a-b
// (R09) p6 high bits 1:0 pick pin 4: port, analog ten, serial2 transmit
// (R10) p7 high bits 3:0 switch pins 7..4 to lcd commons 0..3
// (R11) p7 low 2-bit fields pick pins 3..0: port, lcd bias, pwm outputs
// (R12) p8 function bit n connects pin n to lcd segment n
// (R13) port seven registers all reset to zero, pins start as inputs
// (R14) irq17, irq18, counter 7, serial2 receive sampled only when input
// (R15) a chosen alternate function drives or samples the pin instead
module pmx_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [pmx_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [pmx_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// peripherals
	input wire pmx_pkg::pmx_periph_t periph_in,
	output pmx_pkg::pmx_fnin_t fn_out,
	// pins
	input wire logic [4:0] p6_in,
	output pmx_pkg::pmx_pins_t p6_pin,
	output logic [4:0] p6_analog_sel,
	input wire logic [7:0] p7_in,
	output pmx_pkg::pmx_pins_t p7_pin,
	output logic [7:0] p7_analog_sel,
	input wire logic [7:0] p8_in,
	output pmx_pkg::pmx_pins_t p8_pin,
	output logic [7:0] p8_analog_sel,
	// port six data/direction from the rest of the chip
	input wire logic [4:0] p6_data,
	input wire logic [4:0] p6_dir
);
	import pmx_pkg::*;

	logic [7:0] p7_dat_r, p8_dat_r, p7_pu_r, p8_pu_r, p7_dir_r, p8_dir_r;
	logic [7:0] p7_od_r, p8_od_r, p8_fsr_r, p6_fsrl_r, p6_fsrh_r;
	logic [7:0] p7_fsrl_r, p7_fsrh_r;
	logic [4:0] p6_s1_r, p6_s2_r;
	logic [7:0] p7_s1_r, p7_s2_r, p8_s1_r, p8_s2_r;
	logic aw_got_r, w_got_r;
	logic [15:0] aw_idx_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;

	// synchronise pad inputs before anything reads them
	always_ff @(posedge aclk) begin
		p6_s1_r <= p6_in;
		p6_s2_r <= p6_s1_r;
		p7_s1_r <= p7_in;
		p7_s2_r <= p7_s1_r;
		p8_s1_r <= p8_in;
		p8_s2_r <= p8_s1_r;
	end

	// write channel: address and data accepted in either order
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
	wire [15:0] wr_idx = aw_idx_r;
	wire wr_lane = ws_r[0];
	wire [7:0] wbyte = wd_r[7:0];
	wire wr_hit = (wr_idx == IDX_P7_DATA) || (wr_idx == IDX_P8_DATA) ||
		(wr_idx == IDX_P7_PU) || (wr_idx == IDX_P8_PU) ||
		(wr_idx == IDX_P7_DIR) || (wr_idx == IDX_P8_DIR) ||
		(wr_idx == IDX_P7_OD) || (wr_idx == IDX_P8_OD) ||
		(wr_idx == IDX_P8_FSR) || (wr_idx == IDX_P6_FSRL) ||
		(wr_idx == IDX_P6_FSRH) || (wr_idx == IDX_P7_FSRL) ||
		(wr_idx == IDX_P7_FSRH) || (wr_idx == IDX_P6_PIN);
	wire wr_en = wr_go && wr_hit && wr_lane;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_idx_r <= 16'h0000;
			wd_r <= 32'h0000_0000;
			ws_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_got_r && !aw_take && !s_axi_bvalid;
			s_axi_wready <= !w_got_r && !w_take && !s_axi_bvalid;
			if (aw_take) begin
				aw_got_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr[ADDR_W-1:2];
			end
			if (w_take) begin
				w_got_r <= 1'b1;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// registers; all reset to zero so pins start as port inputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p7_dat_r <= RST_VAL; // see (R13)
			p7_dir_r <= RST_VAL; // see (R13)
			p7_pu_r <= RST_VAL; // see (R13)
			p7_od_r <= RST_VAL; // see (R13)
			p8_dat_r <= RST_VAL;
			p8_dir_r <= RST_VAL;
			p8_pu_r <= RST_VAL;
			p8_od_r <= RST_VAL;
			p8_fsr_r <= RST_VAL;
			p6_fsrl_r <= RST_VAL;
			p6_fsrh_r <= RST_VAL;
			p7_fsrl_r <= RST_VAL;
			p7_fsrh_r <= RST_VAL;
		end else if (wr_en) begin
			case (wr_idx)
				IDX_P7_DATA: p7_dat_r <= wbyte; // see (R01)
				IDX_P8_DATA: p8_dat_r <= wbyte; // see (R01)
				IDX_P7_PU: p7_pu_r <= wbyte;
				IDX_P8_PU: p8_pu_r <= wbyte;
				IDX_P7_DIR: p7_dir_r <= wbyte;
				IDX_P8_DIR: p8_dir_r <= wbyte;
				IDX_P7_OD: p7_od_r <= wbyte;
				IDX_P8_OD: p8_od_r <= wbyte;
				IDX_P8_FSR: p8_fsr_r <= wbyte;
				IDX_P6_FSRL: p6_fsrl_r <= wbyte;
				IDX_P6_FSRH: p6_fsrh_r <= wbyte & P6H_MASK;
				IDX_P7_FSRL: p7_fsrl_r <= wbyte;
				IDX_P7_FSRH: p7_fsrh_r <= wbyte & P7H_MASK;
				default: ;
			endcase
		end
	end

	// read channel; data register reads return the synchronised pins
	wire [15:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
	logic [7:0] rd_byte;
	logic rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		case (rd_idx)
			IDX_P7_DATA: rd_byte = p7_s2_r;
			IDX_P8_DATA: rd_byte = p8_s2_r;
			IDX_P7_PU: rd_byte = p7_pu_r;
			IDX_P8_PU: rd_byte = p8_pu_r;
			IDX_P7_DIR: rd_byte = p7_dir_r;
			IDX_P8_DIR: rd_byte = p8_dir_r;
			IDX_P7_OD: rd_byte = p7_od_r;
			IDX_P8_OD: rd_byte = p8_od_r;
			IDX_P8_FSR: rd_byte = p8_fsr_r;
			IDX_P6_FSRL: rd_byte = p6_fsrl_r;
			IDX_P6_FSRH: rd_byte = p6_fsrh_r;
			IDX_P7_FSRL: rd_byte = p7_fsrl_r;
			IDX_P7_FSRH: rd_byte = p7_fsrh_r;
			IDX_P6_PIN: rd_byte = {3'h0, p6_s2_r};
			default: begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end
	wire ar_take = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !ar_take && !s_axi_rvalid;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_byte};
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// port six function fields
	wire [1:0] f60 = p6_fsrl_r[1:0];
	wire [1:0] f61 = p6_fsrl_r[3:2];
	wire [1:0] f62 = p6_fsrl_r[5:4];
	wire [1:0] f63 = p6_fsrl_r[7:6];
	wire [1:0] f64 = p6_fsrh_r[1:0];

	// port six: only digital outputs override; analog picks release the pad
	logic [4:0] n6_o, n6_oe, n6_an;
	always_comb begin
		n6_o = p6_data;
		n6_oe = p6_dir;
		n6_an = 5'h00;
		case (f60) // see (R08)
			FN_ALT1: begin n6_oe[0] = 1'b0; n6_an[0] = 1'b1; end
			FN_ALT2: begin n6_oe[0] = 1'b1; n6_o[0] = periph_in.pwm_out_a_b; end
			default: ;
		endcase
		case (f61) // see (R07)
			FN_ALT1: begin n6_oe[1] = 1'b0; n6_an[1] = 1'b1; end
			FN_ALT2: begin
				n6_oe[1] = 1'b1;
				n6_o[1] = periph_in.timer_eight_output | periph_in.pwm_out_a_a;
			end
			default: ;
		endcase
		case (f62) // see (R06)
			FN_ALT1: begin n6_oe[2] = 1'b0; n6_an[2] = 1'b1; end
			FN_ALT2: begin
				n6_oe[2] = 1'b1;
				n6_o[2] = periph_in.timer_seven_output;
			end
			default: ;
		endcase
		case (f63) // see (R05)
			FN_ALT1, FN_ALT2: begin n6_oe[3] = 1'b0; n6_an[3] = 1'b1; end
			default: ;
		endcase
		case (f64) // see (R09)
			FN_ALT1: begin n6_oe[4] = 1'b0; n6_an[4] = 1'b1; end
			FN_ALT2: begin
				n6_oe[4] = 1'b1;
				n6_o[4] = periph_in.serial2_transmit_out;
			end
			default: ;
		endcase
	end

	// ports seven and eight: per-pin selection in one loop
	logic [7:0] n7_o, n7_oe, n7_an, n8_o, n8_oe, n8_an, n7_ou, n8_ou;
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			// push-pull drives data; open-drain only pulls low
			wire od7 = p7_od_r[g] && p7_dat_r[g]; // see (R04)
			wire od8 = p8_od_r[g] && p8_dat_r[g]; // see (R04)
			wire pe7 = p7_dir_r[g] && !od7; // see (R02)
			wire pe8 = p8_dir_r[g] && !od8; // see (R02)
			if (g >= 4) begin : g_com
				wire com = p7_fsrh_r[g-4]; // see (R10)
				assign n7_an[g] = com;
				assign n7_oe[g] = com ? 1'b0 : pe7; // see (R15)
				assign n7_ou[g] = com ? 1'b0 : p7_pu_r[g];
				assign n7_o[g] = com ? 1'b0 : p7_dat_r[g];
			end else begin : g_lo
				wire [1:0] fs = p7_fsrl_r[2*g+1:2*g]; // see (R11)
				wire [7:0] pw = {periph_in.pwm_out_c_b, periph_in.pwm_out_c_a,
					periph_in.pwm_out_b_b, periph_in.pwm_out_b_a, 4'h0};
				assign n7_an[g] = (fs == FN_ALT1);
				assign n7_oe[g] = (fs == FN_ALT2) ? 1'b1 :
					(fs == FN_PORT) ? pe7 : 1'b0; // see (R15)
				assign n7_o[g] = (fs == FN_ALT2) ? pw[4+g] : p7_dat_r[g];
				assign n7_ou[g] = (fs == FN_PORT) ? p7_pu_r[g] : 1'b0;
			end
			assign n8_an[g] = p8_fsr_r[g]; // see (R12)
			assign n8_oe[g] = p8_fsr_r[g] ? 1'b1 : pe8; // see (R15)
			assign n8_o[g] = p8_fsr_r[g] ? periph_in.lcd_segment[g]
				: p8_dat_r[g];
			assign n8_ou[g] = p8_fsr_r[g] ? 1'b0 : p8_pu_r[g]; // see (R03)
		end
	endgenerate

	// peripheral inputs gated by direction, seen only in port mode
	wire in6_2 = (f62 == FN_PORT) && !p6_dir[2];
	wire in6_1 = (f61 == FN_PORT) && !p6_dir[1];
	wire in6_3 = (f63 == FN_PORT) && !p6_dir[3];
	wire in6_5 = !p6_dir[4] && (f64 == FN_PORT);

	// all outputs registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p6_pin <= '0;
			p7_pin <= '0;
			p8_pin <= '0;
			p6_analog_sel <= 5'h00;
			p7_analog_sel <= 8'h00;
			p8_analog_sel <= 8'h00;
			fn_out <= '0;
		end else begin
			p6_pin <= '{o: {3'h0, n6_o}, oe: {3'h0, n6_oe}, pu: 8'h00};
			p7_pin <= '{o: n7_o, oe: n7_oe, pu: n7_ou}; // see (R03)
			p8_pin <= '{o: n8_o, oe: n8_oe, pu: n8_ou};
			p6_analog_sel <= n6_an;
			p7_analog_sel <= n7_an;
			p8_analog_sel <= n8_an;
			fn_out.ext_irq_line_17 <= in6_2 & p6_s2_r[2]; // see (R14)
			fn_out.ext_irq_line_18 <= in6_1 & p6_s2_r[1]; // see (R14)
			fn_out.event_counter_input_7 <= in6_3 & p6_s2_r[3]; // see (R14)
			fn_out.serial2_receive_in <= in6_5 & p6_s2_r[4]; // see (R14)
			fn_out.analog_channel_eight <= (f62 == FN_ALT1);
			fn_out.analog_channel_nine <= (f63 == FN_ALT1);
			fn_out.analog_channel_ten <= (f64 == FN_ALT1);
			fn_out.low_voltage_ref_input <= (f63 == FN_ALT2);
			fn_out.lcd_cap_low_pin <= (f61 == FN_ALT1);
			fn_out.lcd_cap_high_pin <= (f60 == FN_ALT1);
		end
	end

	// pin 7 of port seven drives nothing while on a common line
	chk_com_release: assert property (@(posedge aclk) disable iff (!aresetn) // see (R10)
		p7_fsrh_r[3] |=> !p7_pin.oe[7]) else $error("common pin driven");
	chk_seg_drive: assert property (@(posedge aclk) disable iff (!aresetn) // see (R12)
		p8_fsr_r[0] |=> p8_pin.oe[0]) else $error("segment pin not driven");
	chk_dir_input: assert property (@(posedge aclk) disable iff (!aresetn) // see (R02)
		(p7_dir_r[0] == 1'b0 && p7_fsrl_r[1:0] == 2'h0) |=> !p7_pin.oe[0])
		else $error("input pin driven");
	chk_pu_follow: assert property (@(posedge aclk) disable iff (!aresetn) // see (R03)
		(p8_fsr_r[1] == 1'b0) |=> p8_pin.pu[1] == $past(p8_pu_r[1]))
		else $error("pull-up mismatch");
	chk_od_high: assert property (@(posedge aclk) disable iff (!aresetn) // see (R04)
		(p8_od_r[2] && p8_dat_r[2] && !p8_fsr_r[2]) |=> !p8_pin.oe[2])
		else $error("open-drain drove high");
	chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn) // see (R14)
		p6_dir[2] |=> !fn_out.ext_irq_line_17) else $error("irq17 leaked");
	chk_tx_drive: assert property (@(posedge aclk) disable iff (!aresetn) // see (R09)
		(f64 == FN_ALT2) |=> (p6_pin.oe[4] && p6_pin.o[4] ==
		$past(periph_in.serial2_transmit_out))) else $error("tx not routed");
	chk_p6_an9: assert property (@(posedge aclk) disable iff (!aresetn) // see (R05)
		(f63 == FN_ALT1) |=> fn_out.analog_channel_nine)
		else $error("analog nine missing");
	chk_reset_zero: assert property (@(posedge aclk) // see (R13)
		!aresetn |=> (p7_dir_r == 8'h00 && p7_dat_r == 8'h00))
		else $error("port seven reset");
	chk_write_data: assert property (@(posedge aclk) disable iff (!aresetn) // see (R01)
		(wr_en && wr_idx == IDX_P7_DATA) |=> p7_dat_r == $past(wbyte))
		else $error("data write lost");
endmodule // pmx_top

// ==== bench/pmx_tb.sv ====
// self-checking testbench for the port six to eight pin multiplexer
`timescale 1ns/1ps
module testbench;
	import pmx_pkg::*;
	logic aclk, aresetn;
	logic [17:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	pmx_periph_t per;
	pmx_fnin_t fn;
	pmx_pins_t p6p, p7p, p8p;
	logic [4:0] p6_in, p6_data, p6_dir, p6_as;
	logic [7:0] p7_in, p8_in, p7_as, p8_as;
	int fails, total_checks;
	logic [7:0] rd;
	logic [1:0] rs;

	pmx_top i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .periph_in(per), .fn_out(fn),
		.p6_in(p6_in), .p6_pin(p6p), .p6_analog_sel(p6_as),
		.p7_in(p7_in), .p7_pin(p7p), .p7_analog_sel(p7_as),
		.p8_in(p8_in), .p8_pin(p8p), .p8_analog_sel(p8_as),
		.p6_data(p6_data), .p6_dir(p6_dir));

	initial begin
		aclk = 0;
		forever #4 aclk = ~aclk;
	end

	task automatic close_out();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// bounded waits; a bound that runs out ends the run
	task automatic timed_out(input int n);
		if (n >= 100) begin
			fails++;
			close_out();
		end
	endtask

	function automatic logic [17:0] ba(input logic [15:0] i);
		return {i, 2'b00};
	endfunction

	task automatic wr(input logic [15:0] i, input logic [7:0] d);
		int n;
		logic aw, w;
		aw = 1;
		w = 1;
		n = 0;
		awaddr <= ba(i);
		wdata <= {24'h000000, d};
		wstrb <= 4'hF;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while ((aw || w) && n < 100) begin
			@(posedge aclk);
			n++;
			if (aw && awready) begin
				aw = 0;
				awvalid <= 0;
			end
			if (w && wready) begin
				w = 0;
				wvalid <= 0;
			end
		end
		while (bvalid !== 1'b1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		timed_out(n);
		rs = bresp;
		bready <= 0;
		@(posedge aclk);
	endtask

	task automatic rdr(input logic [15:0] i);
		int n;
		n = 0;
		araddr <= ba(i);
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			n++;
		end while (arready !== 1'b1 && n < 100);
		arvalid <= 0;
		while (rvalid !== 1'b1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		timed_out(n);
		rd = rdata[7:0];
		check("rdata upper bits", rdata[31:8], 0);
		rs = rresp;
		rready <= 0;
		@(posedge aclk);
	endtask

	// outputs trail a register update by one cycle, inputs by two or three
	task automatic settle();
		repeat (4) @(posedge aclk);
	endtask

	task automatic scen_reset();
		logic [15:0] idx [12] = '{IDX_P7_DATA, IDX_P8_DATA, IDX_P7_PU,
			IDX_P8_PU, IDX_P7_DIR, IDX_P8_DIR, IDX_P7_OD, IDX_P8_OD,
			IDX_P8_FSR, IDX_P6_FSRL, IDX_P7_FSRL, IDX_P7_FSRH};
		foreach (idx[k]) begin
			rdr(idx[k]);
			check("reset value", rd, RST_VAL);
			check("reset resp", rs, RESP_OKAY);
		end
		check("p7 oe at reset", p7p.oe, 0);
		check("p7 pu at reset", p7p.pu, 0);
	endtask

	task automatic scen_port_regs();
		wr(IDX_P7_DIR, 8'h3C);
		rdr(IDX_P7_DIR);
		check("p7 dir readback", rd, 8'h3C);
		wr(IDX_P7_DATA, 8'hA5);
		wr(IDX_P7_PU, 8'h5A);
		wr(IDX_P8_PU, 8'hC3);
		wr(IDX_P8_DIR, 8'hFF);
		wr(IDX_P8_DATA, 8'h96);
		p7_in <= 8'h3C;
		settle();
		check("p7 oe from dir", p7p.oe, 8'h3C);
		check("p7 out latch", p7p.o & 8'h3C, 8'h24);
		check("p7 pull-up", p7p.pu, 8'h5A);
		check("p8 pull-up", p8p.pu, 8'hC3);
		check("p8 out latch", p8p.o, 8'h96);
		rdr(IDX_P7_DATA);
		check("p7 pin read", rd, 8'h3C);
		// open-drain releases the pin where the latch holds a one
		wr(IDX_P8_OD, 8'h0F);
		settle();
		check("p8 open-drain oe", p8p.oe, 8'hF9);
		wr(IDX_P8_OD, 8'h00);
		settle();
		check("p8 push-pull oe", p8p.oe, 8'hFF);
	endtask

	task automatic scen_p6();
		wr(IDX_P6_FSRL, 8'h55);
		settle();
		check("analog nine", fn.analog_channel_nine, 1);
		check("analog eight", fn.analog_channel_eight, 1);
		check("cap low", fn.lcd_cap_low_pin, 1);
		check("cap high", fn.lcd_cap_high_pin, 1);
		check("lvi ref off", fn.low_voltage_ref_input, 0);
		check("p6 analog sel", p6_as, 5'h0F);
		per.timer_seven_output <= 1;
		per.pwm_out_a_a <= 1;
		wr(IDX_P6_FSRL, 8'hAA);
		settle();
		check("lvi ref", fn.low_voltage_ref_input, 1);
		check("analog nine off", fn.analog_channel_nine, 0);
		check("p6 alt out a", p6p.o[2:0], 3'b110);
		check("p6 alt oe", p6p.oe[3:0], 4'h7);
		per.timer_seven_output <= 0;
		per.pwm_out_a_a <= 0;
		per.timer_eight_output <= 1;
		per.pwm_out_a_b <= 1;
		settle();
		check("p6 alt out b", p6p.o[2:0], 3'b011);
		wr(IDX_P6_FSRL, 8'hFF);
		p6_dir <= 5'h1F;
		p6_data <= 5'h0A;
		settle();
		check("p6 reserved is port", p6p.o[3:0], 4'hA);
		wr(IDX_P6_FSRL, 8'h00);
		p6_dir <= 5'h00;
		p6_in <= 5'h0C;
		settle();
		check("irq17 as input", fn.ext_irq_line_17, 1);
		check("counter7 as input", fn.event_counter_input_7, 1);
		check("irq18 low", fn.ext_irq_line_18, 0);
		p6_dir <= 5'h04;
		settle();
		check("irq17 gated", fn.ext_irq_line_17, 0);
		check("counter7 kept", fn.event_counter_input_7, 1);
		wr(IDX_P6_FSRH, 8'h01);
		settle();
		check("analog ten", fn.analog_channel_ten, 1);
		check("p6 pin4 analog", p6_as, 5'h10);
		per.serial2_transmit_out <= 1;
		wr(IDX_P6_FSRH, 8'hFF);
		rdr(IDX_P6_FSRH);
		check("p6 high mask", rd, P6H_MASK);
		wr(IDX_P6_FSRH, 8'h02);
		settle();
		check("serial2 tx pin", p6p.o[4], 1);
		check("analog ten off", fn.analog_channel_ten, 0);
	endtask

	task automatic scen_p7_p8();
		wr(IDX_P7_FSRL, 8'h55);
		settle();
		check("p7 bias select", p7_as[3:0], 4'hF);
		per.pwm_out_c_b <= 1;
		per.pwm_out_b_a <= 1;
		wr(IDX_P7_FSRL, 8'hAA);
		settle();
		check("p7 pwm pins", p7p.o[3:0], 4'b1001);
		check("p7 pwm not analog", p7_as[3:0], 4'h0);
		// one source alone tells pin 3 from pin 0
		per.pwm_out_b_a <= 0;
		settle();
		check("p7 pwm order", p7p.o[3:0], 4'b1000);
		wr(IDX_P7_FSRH, 8'hFF);
		rdr(IDX_P7_FSRH);
		check("p7 high mask", rd, P7H_MASK);
		wr(IDX_P7_FSRH, 8'h09);
		settle();
		check("p7 common select", p7_as[7:4], 4'h9);
		wr(IDX_P8_FSR, 8'hA5);
		rdr(IDX_P8_FSR);
		check("p8 fsr readback", rd, 8'hA5);
		settle();
		check("p8 segment select", p8_as, 8'hA5);
		per.lcd_segment <= 8'h0F;
		settle();
		check("p8 segment out", p8p.o, 8'h17);
		check("p8 segment oe", p8p.oe, 8'hFF);
	endtask

	task automatic scen_bus_errors();
		wr(16'h0093, 8'h11);
		check("unmapped write resp", rs, RESP_SLVERR);
		rdr(16'h0093);
		check("unmapped read resp", rs, RESP_SLVERR);
		check("unmapped read data", rd, 8'h00);
	endtask

	// reset in mid-run must bring port seven back to a quiet input
	task automatic scen_mid_reset();
		wr(IDX_P7_DATA, 8'h5A);
		wr(IDX_P7_DIR, 8'hFF);
		wr(IDX_P7_PU, 8'hFF);
		wr(IDX_P7_OD, 8'h0F);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		rdr(IDX_P7_DIR);
		check("p7 dir after reset", rd, RST_VAL);
		rdr(IDX_P7_PU);
		check("p7 pu after reset", rd, RST_VAL);
		rdr(IDX_P7_OD);
		check("p7 od after reset", rd, RST_VAL);
		check("p7 latch after reset", p7p.o, 0);
		check("p7 oe after reset", p7p.oe, 0);
		check("p7 pu pins after reset", p7p.pu, 0);
	endtask

	initial begin
		{awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} <= '0;
		{wdata, wstrb, per, p6_in, p6_data, p6_dir, p7_in, p8_in} <= '0;
		fails = 0;
		total_checks = 0;
		aresetn <= 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		scen_reset();
		scen_port_regs();
		scen_p6();
		scen_p7_p8();
		scen_bus_errors();
		scen_mid_reset();
		close_out();
	end

	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		close_out();
	end
endmodule // testbench
